// File: hw/capc_top.sv
/*
  Core activity and power control: running, debug halt and power/firmware
  halt states, four-phase handshakes with the power unit, unacknowledged halt/run requests from the multi-core
  controller, cycle counter gating, APB register access.
  Assumes asynchronous request inputs and a core that reports quiescence.
*/
// Chosen here: the register addresses and the APB interface to the registers.
// Function
// - halt status high only in power/firmware halt state.
// - debug status high in debug halt, including during single-step resume.
// - cycle counter counts while running, frozen in power halt.
// - in debug halt the counter counts unless stop-count bit is set.
// - debug halt actions win over power or firmware halt.
// - power halt ignored in debug mode, honored on exit if still held.
// - no firmware halt in debug mode, none pending across exit.
// - debug entry on halt, step, breakpoint, trigger or controller halt.
// - debug exit only on plain resume or controller run.
// - debug halt is the only halted state in debug mode.
// - debug entry overrides any power request in progress.
// - incoming handshake requests are synchronised to the core clock.
// - all power control and status signals are active high.
// - halt request: quiesce, halt, ack until request drops.
// - request for the current state gets no acknowledge.
// - quiesced means no issue and no outstanding core bus traffic.
`timescale 1ns/10ps
module capc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // power unit handshake
  input  wire logic        cpu_halt_req,
  input  wire logic        cpu_run_req,
  output logic             cpu_halt_ack,
  output logic             cpu_run_ack,
  output logic             cpu_halt_status,
  // multi-core controller
  input  wire logic        mpc_halt_req,
  input  wire logic        mpc_run_req,
  output logic             debug_mode_status,
  // core pipeline
  input  wire logic        core_idle,
  input  wire logic        bus_outstanding,
  output logic             issue_stall,
  output logic             clk_gate_en
);

  capc_sync_if sif ();

  assign sif.halt_req_raw = cpu_halt_req;
  assign sif.run_req_raw  = cpu_run_req;
  assign sif.mpc_halt_raw = mpc_halt_req;
  assign sif.mpc_run_raw  = mpc_run_req;

  capc_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sif     (sif)
  );

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  wire apb_acc   = psel && penable;
  wire apb_wr    = apb_acc && pwrite;
  wire hit_ctrl  = (paddr == capc_pkg::ADDR_CTRL);
  wire hit_stat  = (paddr == capc_pkg::ADDR_STATUS);
  wire hit_lo    = (paddr == capc_pkg::ADDR_CYC_LO);
  wire hit_hi    = (paddr == capc_pkg::ADDR_CYC_HI);
  wire hit_dbg   = (paddr == capc_pkg::ADDR_DBGCMD);
  wire hit_any   = hit_ctrl | hit_stat | hit_lo | hit_hi | hit_dbg;
  wire dbg_wr    = apb_wr && hit_dbg;
  wire [31:0] dbg_cmd = dbg_wr ? pwdata : 32'h0000_0000;

  logic [1:0]  ctrl_reg;
  logic [63:0] cycle_reg;
  logic        step_reg;
  capc_pkg::capc_state_t state_reg;
  capc_pkg::capc_state_t state_next;
  logic        core_dbg_reg;
  logic        mpc_dbg_reg;
  logic        halt_ack_reg;
  logic        run_ack_reg;

  wire stopcount = ctrl_reg[capc_pkg::CTRL_STOPCOUNT];
  wire fw_halt   = ctrl_reg[capc_pkg::CTRL_FW_HALT];
  wire in_debug  = (state_reg == capc_pkg::ST_DBG_HALT);

  // ------------------------------------------------------------------
  // debug entry and exit decode
  // ------------------------------------------------------------------
  // a bare step from running halts like any other debug action
  wire dbg_halt_act = dbg_cmd[capc_pkg::DBG_HALT] | dbg_cmd[capc_pkg::DBG_STEP]
                    | dbg_cmd[capc_pkg::DBG_BRKPT] | dbg_cmd[capc_pkg::DBG_TRIG]
                    | step_reg;
  wire mpc_enter    = sif.mpc_halt_s && !mpc_dbg_reg;
  wire dbg_enter    = !in_debug && (dbg_halt_act || mpc_enter);
  // step requested while in debug resumes for one instruction then re-halts
  wire step_resume  = dbg_cmd[capc_pkg::DBG_RESUME] && dbg_cmd[capc_pkg::DBG_STEP];
  wire core_resume  = core_dbg_reg && dbg_cmd[capc_pkg::DBG_RESUME]
                    && !dbg_cmd[capc_pkg::DBG_STEP];
  wire mpc_resume   = mpc_dbg_reg && sif.mpc_run_s;
  // stay halted while the other source still holds the core
  wire core_left    = core_dbg_reg && !core_resume && !step_resume;
  wire mpc_left     = mpc_dbg_reg && !mpc_resume;
  wire dbg_exit     = in_debug && (core_resume || mpc_resume || step_resume)
                    && !core_left && !mpc_left;
  wire quiesced     = core_idle && !bus_outstanding;
  wire pwr_halt_go  = sif.halt_req_s || fw_halt;

  // ------------------------------------------------------------------
  // activity state machine
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (dbg_enter) begin
      state_next = capc_pkg::ST_DBG_HALT;
    end else begin
      case (state_reg)
        capc_pkg::ST_RUNNING: begin
          if (pwr_halt_go && !halt_ack_reg) begin
            state_next = capc_pkg::ST_QUIESCE;
          end
        end
        capc_pkg::ST_QUIESCE: begin
          if (quiesced) begin
            state_next = capc_pkg::ST_PWR_HALT;
          end
        end
        capc_pkg::ST_PWR_HALT: begin
          if (sif.run_req_s && !run_ack_reg) begin
            state_next = capc_pkg::ST_RUNNING;
          end
        end
        capc_pkg::ST_DBG_HALT: begin
          // power requests are not looked at here, only debug exit
          if (dbg_exit) begin
            state_next = capc_pkg::ST_RUNNING;
          end
        end
        default: state_next = capc_pkg::ST_RUNNING;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= capc_pkg::ST_RUNNING;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // debug source bits, cleared on exit
  // ------------------------------------------------------------------
  wire core_dbg_next = (state_next == capc_pkg::ST_DBG_HALT)
                     && (core_dbg_reg || dbg_halt_act) && !core_resume && !step_resume;
  wire mpc_dbg_next  = (state_next == capc_pkg::ST_DBG_HALT)
                     && (mpc_dbg_reg || sif.mpc_halt_s) && !mpc_resume;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_dbg_reg <= 1'b0;
      mpc_dbg_reg  <= 1'b0;
      step_reg     <= 1'b0;
    end else begin
      core_dbg_reg <= core_dbg_next;
      mpc_dbg_reg  <= mpc_dbg_next;
      step_reg     <= in_debug && step_resume && !mpc_dbg_reg;
    end
  end

  // ------------------------------------------------------------------
  // power unit handshake acknowledges
  // ------------------------------------------------------------------
  wire halt_ack_set = sif.halt_req_s && (state_reg == capc_pkg::ST_QUIESCE)
                    && (state_next == capc_pkg::ST_PWR_HALT);
  wire halt_ack_nxt = halt_ack_set || (halt_ack_reg && sif.halt_req_s);
  wire run_ack_set  = sif.run_req_s && (state_reg == capc_pkg::ST_PWR_HALT)
                    && (state_next == capc_pkg::ST_RUNNING);
  wire run_ack_nxt  = run_ack_set || (run_ack_reg && sif.run_req_s);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      halt_ack_reg <= 1'b0;
      run_ack_reg  <= 1'b0;
    end else begin
      halt_ack_reg <= halt_ack_nxt;
      run_ack_reg  <= run_ack_nxt;
    end
  end

  // ------------------------------------------------------------------
  // control register; firmware halt self-clears on entering halt
  // ------------------------------------------------------------------
  logic [1:0] ctrl_next;
  always_comb begin
    ctrl_next = ctrl_reg;
    if (apb_wr && hit_ctrl) begin
      ctrl_next[capc_pkg::CTRL_STOPCOUNT] = pwdata[capc_pkg::CTRL_STOPCOUNT];
      // firmware cannot halt from debug mode
      ctrl_next[capc_pkg::CTRL_FW_HALT] = pwdata[capc_pkg::CTRL_FW_HALT] && !in_debug;
    end
    // no firmware halt survives debug or a completed halt
    if ((state_next == capc_pkg::ST_DBG_HALT) || (state_next == capc_pkg::ST_PWR_HALT)) begin
      ctrl_next[capc_pkg::CTRL_FW_HALT] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= capc_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ------------------------------------------------------------------
  // cycle counter
  // ------------------------------------------------------------------
  wire cyc_inc = (state_reg == capc_pkg::ST_RUNNING) || (state_reg == capc_pkg::ST_QUIESCE)
               || (in_debug && !stopcount);
  logic [63:0] cycle_next;
  always_comb begin
    cycle_next = cyc_inc ? cycle_reg + 64'h1 : cycle_reg;
    if (apb_wr && hit_lo) begin
      cycle_next[31:0] = pwdata;
    end
    if (apb_wr && hit_hi) begin
      cycle_next[63:32] = pwdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cycle_reg <= capc_pkg::CYCLE_RESET;
    end else begin
      cycle_reg <= cycle_next;
    end
  end

  // ------------------------------------------------------------------
  // apb read path, no wait states
  // ------------------------------------------------------------------
  wire [31:0] stat_word = {28'h0000000, step_reg, quiesced, debug_mode_status, cpu_halt_status};
  wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_reg}
                     : hit_stat ? stat_word
                     : hit_lo   ? cycle_reg[31:0]
                     : hit_hi   ? cycle_reg[63:32]
                     : 32'h0000_0000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : prdata;
      pslverr <= psel && !penable && !hit_any;
    end
  end

  // ------------------------------------------------------------------
  // status outputs, registered from next state
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_halt_status   <= 1'b0;
      debug_mode_status <= 1'b0;
      cpu_halt_ack      <= 1'b0;
      cpu_run_ack       <= 1'b0;
      issue_stall       <= 1'b0;
      clk_gate_en       <= 1'b0;
    end else begin
      cpu_halt_status   <= (state_next == capc_pkg::ST_PWR_HALT);
      debug_mode_status <= (state_next == capc_pkg::ST_DBG_HALT)
                           || (step_resume && in_debug);
      cpu_halt_ack      <= halt_ack_nxt;
      cpu_run_ack       <= run_ack_nxt;
      issue_stall       <= (state_next != capc_pkg::ST_RUNNING);
      // gating never reaches the synchroniser bank
      clk_gate_en       <= (state_next == capc_pkg::ST_PWR_HALT);
    end
  end

endmodule : capc_top

// File: hw/capc_pkg.sv
/*
  Package for the core activity and power control block: APB register map,
  field positions, reset values, activity-state enumeration.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package capc_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CYC_LO = 8'h08;
  localparam logic [7:0] ADDR_CYC_HI = 8'h0C;
  localparam logic [7:0] ADDR_DBGCMD = 8'h10;

  // ------------------------------------------------------------------
  // ctrl fields
  // ------------------------------------------------------------------
  localparam int CTRL_STOPCOUNT = 0;
  localparam int CTRL_FW_HALT   = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ------------------------------------------------------------------
  // debug command fields (write-one pulses)
  // ------------------------------------------------------------------
  localparam int DBG_HALT   = 0;
  localparam int DBG_RESUME = 1;
  localparam int DBG_STEP   = 2;
  localparam int DBG_BRKPT  = 3;
  localparam int DBG_TRIG   = 4;

  // ------------------------------------------------------------------
  // status fields
  // ------------------------------------------------------------------
  localparam int ST_HALT    = 0;
  localparam int ST_DEBUG   = 1;
  localparam int ST_QUIET   = 2;
  localparam int ST_STEPPING = 3;

  localparam logic [63:0] CYCLE_RESET = 64'h0;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    ST_RUNNING,
    ST_QUIESCE,
    ST_PWR_HALT,
    ST_DBG_HALT
  } capc_state_t;

endpackage : capc_pkg

// File: hw/capc_if.sv
/*
  Interface joining the synchroniser bank to the activity controller.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
interface capc_sync_if;
  logic halt_req_raw;
  logic run_req_raw;
  logic mpc_halt_raw;
  logic mpc_run_raw;
  logic halt_req_s;
  logic run_req_s;
  logic mpc_halt_s;
  logic mpc_run_s;

  modport sync (input halt_req_raw, run_req_raw, mpc_halt_raw, mpc_run_raw,
                output halt_req_s, run_req_s, mpc_halt_s, mpc_run_s);
  modport ctl  (output halt_req_raw, run_req_raw, mpc_halt_raw, mpc_run_raw,
                input halt_req_s, run_req_s, mpc_halt_s, mpc_run_s);
endinterface : capc_sync_if

// File: hw/capc_sync.sv
/*
  Two-flop synchronisers for the asynchronous request inputs.
  Assumes clk is never gated here, so a wake request is always seen.
*/
`timescale 1ns/10ps
module capc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request bundle
  capc_sync_if.sync sif
);

  logic [3:0] raw;
  wire  [3:0] sync_bits;

  assign raw = {sif.mpc_run_raw, sif.mpc_halt_raw, sif.run_req_raw, sif.halt_req_raw};

  // ------------------------------------------------------------------
  // one generate loop, one synchroniser per request
  // ------------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_sync
    // per-stage flops local to the loop, so each process owns its own variables
    logic meta_reg;
    logic sync_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
      end else begin
        meta_reg <= raw[i];
        sync_reg <= meta_reg;
      end
    end
    assign sync_bits[i] = sync_reg;
  end

  assign sif.halt_req_s = sync_bits[0];
  assign sif.run_req_s  = sync_bits[1];
  assign sif.mpc_halt_s = sync_bits[2];
  assign sif.mpc_run_s  = sync_bits[3];

endmodule : capc_sync

// File: testbench/capc_pmu_model.sv
/* Power unit model: four-phase halt and run handshakes toward the core.
   Assumes the testbench calls raise then finish, one request at a time. */
`timescale 1ns/10ps
module capc_pmu_model (
  // clock
  input  wire logic clk,
  // handshake
  output logic      cpu_halt_req,
  output logic      cpu_run_req,
  input  wire logic cpu_halt_ack,
  input  wire logic cpu_run_ack
);
  // idle level when unused is zero
  initial begin
    cpu_halt_req = 1'b0;
    cpu_run_req  = 1'b0;
  end

  // never both lines up together
  task automatic raise(input logic run);
    @(posedge clk);
    if (run) cpu_run_req <= 1'b1;
    else cpu_halt_req <= 1'b1;
  endtask : raise

  // hold until ack; a refused request is withdrawn after max cycles
  task automatic finish(input logic run, input int max, output logic ok);
    int i;
    ok = 1'b0;
    for (i = 0; i < max && !ok; i++) begin
      @(posedge clk);
      ok = ((run ? cpu_run_ack : cpu_halt_ack) === 1'b1);
    end
    cpu_halt_req <= 1'b0;
    cpu_run_req  <= 1'b0;
    for (i = 0; i < max && (cpu_halt_ack | cpu_run_ack); i++) @(posedge clk);
    // an ack that never drops fails the handshake
    if (cpu_halt_ack | cpu_run_ack) ok = 1'b0;
  endtask : finish
endmodule : capc_pmu_model

// File: testbench/capc_chk_sva.sv
/* Checker for capc_top: activity state, status and handshake relations.
   Assumes one clock domain; attached by the bind at the foot. */
`timescale 1ns/10ps
module capc_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // power unit
  input wire logic cpu_halt_req,
  input wire logic cpu_run_req,
  input wire logic cpu_halt_ack,
  input wire logic cpu_run_ack,
  input wire logic cpu_halt_status,
  // status and core
  input wire logic debug_mode_status,
  input wire logic issue_stall,
  input wire logic clk_gate_en,
  input wire logic core_idle,
  input wire logic bus_outstanding
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_halt_not_debug: assert property (cpu_halt_status |-> !debug_mode_status)
    else $error("halt status high together with debug status");
  a_dbg_no_gate: assert property (debug_mode_status |-> !clk_gate_en)
    else $error("deep gating while in debug halt");
  a_halted_stalls: assert property (cpu_halt_status |-> issue_stall && clk_gate_en)
    else $error("halted core still issuing or ungated");
  a_halt_quiet: assert property ($rose(cpu_halt_status)
    |-> $past(core_idle && !bus_outstanding))
    else $error("halted before the core was quiesced");
  a_halt_ack_rise: assert property ($rose(cpu_halt_ack) |-> cpu_halt_status && !$past(cpu_halt_status))
    else $error("halt ack without entering halt");
  a_halt_ack_hold: assert property (cpu_halt_ack && cpu_halt_req |=> cpu_halt_ack)
    else $error("halt ack dropped while request held");
  a_halt_ack_drop: assert property ((!cpu_halt_req) [*6] |-> !cpu_halt_ack)
    else $error("halt ack kept after request dropped");
  a_no_reack: assert property (cpu_halt_status && cpu_halt_req && !cpu_halt_ack |=> !cpu_halt_ack)
    else $error("halt ack while already halted");
  a_run_ack_rise: assert property ($rose(cpu_run_ack) |-> !cpu_halt_status && $past(cpu_halt_status))
    else $error("run ack without leaving halt");
  a_run_wakes: assert property (cpu_run_req && cpu_halt_status && !cpu_run_ack |-> ##[1:12] cpu_run_ack)
    else $error("halted core not woken by run request");
  a_run_no_reack: assert property ($rose(cpu_run_req) && !cpu_halt_status && !debug_mode_status |-> (!cpu_run_ack) [*8])
    else $error("run ack while already running");
  c_halt: cover property ($rose(cpu_halt_ack));
  c_run: cover property ($rose(cpu_run_ack));
  c_dbg: cover property ($rose(debug_mode_status));
  c_step: cover property (debug_mode_status && !issue_stall);
endmodule : capc_chk

bind capc_top capc_chk u_chk (.clk(clk), .sys_rst(sys_rst), .cpu_halt_req(cpu_halt_req),
  .cpu_run_req(cpu_run_req), .cpu_halt_ack(cpu_halt_ack), .cpu_run_ack(cpu_run_ack),
  .cpu_halt_status(cpu_halt_status), .debug_mode_status(debug_mode_status),
  .issue_stall(issue_stall), .clk_gate_en(clk_gate_en), .core_idle(core_idle),
  .bus_outstanding(bus_outstanding));

// File: testbench/capc_top_tb.sv
/* Self-checking bench for capc_top over APB, the power unit model and
   controller request lines. Assumes the capc_pkg register map. */
`timescale 1ns/10ps
module capc_top_tb;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, ok, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cpu_halt_req, cpu_run_req, cpu_halt_ack, cpu_run_ack, cpu_halt_status;
  logic        mpc_halt_req, mpc_run_req, debug_mode_status, bus_outstanding;
  logic        issue_stall, clk_gate_en, core_idle;
  int          n_fail, n_compared;
  int          acts[4] = '{capc_pkg::DBG_HALT, capc_pkg::DBG_STEP,
                           capc_pkg::DBG_BRKPT, capc_pkg::DBG_TRIG};

  capc_top DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_halt_req(cpu_halt_req), .cpu_run_req(cpu_run_req),
    .cpu_halt_ack(cpu_halt_ack), .cpu_run_ack(cpu_run_ack),
    .cpu_halt_status(cpu_halt_status), .mpc_halt_req(mpc_halt_req),
    .mpc_run_req(mpc_run_req), .debug_mode_status(debug_mode_status),
    .core_idle(core_idle), .bus_outstanding(bus_outstanding), .issue_stall(issue_stall),
    .clk_gate_en(clk_gate_en));
  capc_pmu_model pmu (.clk(clk), .cpu_halt_req(cpu_halt_req), .cpu_run_req(cpu_run_req),
    .cpu_halt_ack(cpu_halt_ack), .cpu_run_ack(cpu_run_ack));

  initial begin
    clk = 1'b0;
    // free-running, so the run request synchroniser is never gated
    forever #2 clk = ~clk;
  end

  task automatic results();
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one transfer; sampling edges of back-to-back calls are 3 cycles apart
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      results();
    end
  endtask : apb

  task automatic cyc(input logic [31:0] exp);
    logic [31:0] a;
    apb(1'b0, capc_pkg::ADDR_CYC_LO, 32'h0);
    a = rd;
    apb(1'b0, capc_pkg::ADDR_CYC_LO, 32'h0);
    chk(rd - a, exp);
  endtask : cyc

  task automatic dbg(input logic [31:0] cmd);
    apb(1'b1, capc_pkg::ADDR_DBGCMD, cmd);
    repeat (3) @(posedge clk);
  endtask : dbg

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {mpc_halt_req, mpc_run_req, bus_outstanding} = '0;
    core_idle = 1'b1;
    n_fail = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, capc_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h1 << capc_pkg::ST_QUIET);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    cyc(32'h3);
    // ------------------------------------------------------------
    // power halt and run, repeated requests refused
    // ------------------------------------------------------------
    bus_outstanding <= 1'b1;
    core_idle       <= 1'b0;
    pmu.raise(1'b0);
    repeat (20) @(posedge clk);
    chk(cpu_halt_ack, 1'b0);
    bus_outstanding <= 1'b0;
    apb(1'b0, capc_pkg::ADDR_STATUS, 32'h0);
    chk({rd[30:0], cpu_halt_ack}, 32'h0);
    core_idle <= 1'b1;
    pmu.finish(1'b0, 40, ok);
    chk(ok, 1'b1);
    chk({cpu_halt_status, issue_stall, clk_gate_en}, 32'h7);
    cyc(32'h0);
    pmu.raise(1'b0);
    pmu.finish(1'b0, 20, ok);
    chk(ok, 1'b0);
    pmu.raise(1'b1);
    pmu.finish(1'b1, 40, ok);
    chk({ok, cpu_halt_status}, 32'h2);
    pmu.raise(1'b1);
    pmu.finish(1'b1, 20, ok);
    chk(ok, 1'b0);
    // ------------------------------------------------------------
    // debug actions, stop-count, step resume, firmware halt
    // ------------------------------------------------------------
    foreach (acts[k]) begin
      dbg(32'h1 << acts[k]);
      chk({debug_mode_status, cpu_halt_status}, 32'h2);
      chk({issue_stall, clk_gate_en}, 32'h2);
      cyc(32'h3);
      dbg(32'h1 << capc_pkg::DBG_RESUME);
      chk(debug_mode_status, 1'b0);
    end
    apb(1'b1, capc_pkg::ADDR_CTRL, 32'h1);
    dbg(32'h1 << capc_pkg::DBG_HALT);
    cyc(32'h0);
    dbg((32'h1 << capc_pkg::DBG_RESUME) | (32'h1 << capc_pkg::DBG_STEP));
    chk(debug_mode_status, 1'b1);
    apb(1'b1, capc_pkg::ADDR_CTRL, 32'h2);
    dbg(32'h1 << capc_pkg::DBG_RESUME);
    repeat (10) @(posedge clk);
    chk({debug_mode_status, cpu_halt_status}, 32'h0);
    apb(1'b1, capc_pkg::ADDR_CTRL, 32'h2);
    repeat (10) @(posedge clk);
    chk({debug_mode_status, cpu_halt_status}, 32'h1);
    pmu.raise(1'b1);
    pmu.finish(1'b1, 40, ok);
    chk(ok, 1'b1);
    // ------------------------------------------------------------
    // controller halt wins over a coinciding power halt
    // ------------------------------------------------------------
    pmu.raise(1'b0);
    mpc_halt_req <= 1'b1;
    repeat (12) @(posedge clk);
    chk({debug_mode_status, cpu_halt_status, cpu_halt_ack}, 32'h4);
    mpc_halt_req <= 1'b0;
    mpc_run_req  <= 1'b1;
    repeat (8) @(posedge clk);
    chk(debug_mode_status, 1'b0);
    mpc_run_req <= 1'b0;
    pmu.finish(1'b0, 40, ok);
    chk(ok, 1'b1);
    pmu.raise(1'b1);
    pmu.finish(1'b1, 40, ok);
    chk(ok, 1'b1);
    results();
  end
endmodule : capc_top_tb
